// file: include/pag_defines.svh
`ifndef PAG_DEFINES_SVH
`define PAG_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PAG_ADR_CTRL      8'h00
`define PAG_ADR_CMD       8'h04
`define PAG_ADR_TARGET    8'h08
`define PAG_ADR_WINDOW    8'h0c
`define PAG_ADR_VELOCITY  8'h10
`define PAG_ADR_ACCEL     8'h14
`define PAG_ADR_GEAR_NUM  8'h18
`define PAG_ADR_GEAR_DEN  8'h1c
`define PAG_ADR_STATUS    8'h20
`define PAG_ADR_ENC_POS   8'h24
`define PAG_ADR_SETPOINT  8'h28
`define PAG_ADR_IRQ_STAT  8'h2c
`define PAG_ADR_IRQ_MASK  8'h30
`define PAG_ADR_REPORT    8'h34

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define PAG_CTRL_W        4
`define PAG_CTRL_RST      4'h0
`define PAG_CMD_ACTION    0
`define PAG_IRQ_W         2
`define PAG_IRQ_DONE      0
`define PAG_IRQ_ABORT     1
`define PAG_GEAR_RST      32'h00000001
`define PAG_ACCEL_RST     32'h00000064
`define PAG_VEL_MIN       32'h00000008
`define PAG_ACK_CHAR      8'h58

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PAG_CLK_HZ        32'd125000000
`define PAG_CLK_MHZ       125
`define PAG_RAMP_TICK_US  1000
`define PAG_RAMP_TICK_CYC (`PAG_RAMP_TICK_US * `PAG_CLK_MHZ)

`endif

// file: include/pag_pkg.sv
package pag_pkg;

  typedef enum logic [1:0] {
    PAG_MODE_PTP  = 2'h0,
    PAG_MODE_FREQ = 2'h1,
    PAG_MODE_GEAR = 2'h2
  } pag_mode_type;

  typedef struct packed {
    logic         report_option;
    logic         auto_run;
    pag_mode_type mode;
  } pag_ctrl_type;

  typedef enum logic [2:0] {
    PAG_ST_IDLE   = 3'b001,
    PAG_ST_RUN    = 3'b010,
    PAG_ST_SETTLE = 3'b100
  } pag_state_type;

  typedef struct packed {
    logic       valid;
    logic       report;
    logic [7:0] data;
  } pag_ack_tx_type;

endpackage

// file: src/pag_top.sv
`timescale 1ns/10ps
`include "pag_defines.svh"

module pag_top #(
  parameter int unsigned RAMP_TICK_CYCLES = `PAG_RAMP_TICK_CYC
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output      logic [31:0]             wb_dat_o,
  output      logic                    wb_ack_o,
  input  wire logic                    enc_a_i,
  input  wire logic                    enc_b_i,
  input  wire logic                    gear_a_i,
  input  wire logic                    gear_b_i,
  output      logic                    motor_step_o,
  output      logic                    motor_dir_o,
  output      logic                    in_position_flag_o,
  output      pag_pkg::pag_ack_tx_type ack_tx_o,
  output      logic [31:0]             position_report_value_o,
  output      logic                    irq_o
);

  // --------------------------------------------------------------------------
  // Input synchronisers: three stages, change taken when stages two and three agree
  // --------------------------------------------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] filt;
  logic [3:0] filt_prev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1     <= 4'h0;
      sync2     <= 4'h0;
      sync3     <= 4'h0;
      filt      <= 4'h0;
      filt_prev <= 4'h0;
    end else begin
      sync1     <= {gear_b_i, gear_a_i, enc_b_i, enc_a_i};
      sync2     <= sync1;
      sync3     <= sync2;
      // Per channel, so that edges on A and B one cycle apart are both seen
      filt      <= (sync3 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
      filt_prev <= filt;
    end
  end

  // Returns +1, -1 or 0 for one quadrature transition; A leading B counts up
  function automatic logic [1:0] quad_step(input logic [1:0] old_ba, input logic [1:0] new_ba);
    logic [1:0] r;
    r = 2'h0;
    if ((old_ba ^ new_ba) == 2'h1 || (old_ba ^ new_ba) == 2'h2) begin
      r = (old_ba[0] ^ new_ba[1]) ? 2'h3 : 2'h1;
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  pag_pkg::pag_ctrl_type   ctrl, next_ctrl;
  pag_pkg::pag_state_type  state, next_state;
  pag_pkg::pag_ack_tx_type ack_tx, next_ack_tx;
  logic [31:0] target, next_target;
  logic [31:0] position_window_cmd, next_position_window_cmd;
  logic [31:0] velocity_setpoint_cmd, next_velocity_setpoint_cmd;
  logic [31:0] accel, next_accel;
  logic [31:0] gear_numerator, next_gear_numerator;
  logic [31:0] gear_denominator, next_gear_denominator;
  logic [31:0] gear_num_act, next_gear_num_act;
  logic [31:0] gear_den_act, next_gear_den_act;
  logic [32:0] gear_acc, next_gear_acc;
  logic [31:0] enc_pos, next_enc_pos;
  logic [31:0] setpoint, next_setpoint;
  logic [31:0] freq, next_freq;
  logic [31:0] target_freq, next_target_freq;
  logic        want_dir, next_want_dir;
  logic [31:0] phase, next_phase;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic        in_pos, next_in_pos;
  logic        dir, next_dir;
  logic        step, next_step;
  logic [31:0] report, next_report;
  logic [`PAG_IRQ_W-1:0] irq_stat, next_irq_stat;
  logic [`PAG_IRQ_W-1:0] irq_mask, next_irq_mask;
  logic        ack, next_ack;
  logic [31:0] rdat, next_rdat;

  always_comb begin
    logic        wr;
    logic [31:0] cw;
    logic        action;
    logic        tick;
    logic [1:0]  enc_d;
    logic [1:0]  gear_d;
    logic [31:0] diff;
    logic [31:0] err;
    logic [31:0] mag;
    logic [32:0] psum;
    logic        mstep;
    logic        sp_up;
    logic        sp_dn;
    logic        done_ev;
    logic        abort_ev;
    logic        send_x;
    logic [`PAG_IRQ_W-1:0] ev;
    wr       = 1'b0;
    cw       = 32'h0;
    action   = 1'b0;
    tick     = 1'b0;
    enc_d    = 2'h0;
    gear_d   = 2'h0;
    diff     = 32'h0;
    err      = 32'h0;
    mag      = 32'h0;
    psum     = 33'h0;
    mstep    = 1'b0;
    sp_up    = 1'b0;
    sp_dn    = 1'b0;
    done_ev  = 1'b0;
    abort_ev = 1'b0;
    send_x   = 1'b0;
    ev       = '0;
    next_ctrl                  = ctrl;
    next_state                 = state;
    next_target                = target;
    next_position_window_cmd   = position_window_cmd;
    next_velocity_setpoint_cmd = velocity_setpoint_cmd;
    next_accel                 = accel;
    next_gear_numerator        = gear_numerator;
    next_gear_denominator      = gear_denominator;
    next_gear_num_act          = gear_num_act;
    next_gear_den_act          = gear_den_act;
    next_gear_acc              = gear_acc;
    next_enc_pos               = enc_pos;
    next_setpoint              = setpoint;
    next_freq                  = freq;
    next_target_freq           = target_freq;
    next_want_dir              = want_dir;
    next_phase                 = phase;
    next_in_pos                = in_pos;
    next_dir                   = dir;
    next_step                  = 1'b0;
    next_report                = report;
    next_irq_mask              = irq_mask;
    next_ack_tx                = '0;

    // ------------------------------------------------------------------------
    // Wishbone slave: ack one cycle after the strobe, write at the ack edge
    // ------------------------------------------------------------------------
    next_ack  = wb_cyc_i & wb_stb_i & ~ack;
    wr        = wb_cyc_i & wb_stb_i & wb_we_i & ack;
    next_rdat = rdat;
    if (next_ack) begin
      case (wb_adr_i)
        `PAG_ADR_CTRL:     next_rdat = {28'h0, ctrl};
        `PAG_ADR_TARGET:   next_rdat = target;
        `PAG_ADR_WINDOW:   next_rdat = position_window_cmd;
        `PAG_ADR_VELOCITY: next_rdat = velocity_setpoint_cmd;
        `PAG_ADR_ACCEL:    next_rdat = accel;
        `PAG_ADR_GEAR_NUM: next_rdat = gear_numerator;
        `PAG_ADR_GEAR_DEN: next_rdat = gear_denominator;
        `PAG_ADR_STATUS:   next_rdat = {28'h0, state, in_pos};
        `PAG_ADR_ENC_POS:  next_rdat = enc_pos;
        `PAG_ADR_SETPOINT: next_rdat = setpoint;
        `PAG_ADR_IRQ_STAT: next_rdat = {30'h0, irq_stat};
        `PAG_ADR_IRQ_MASK: next_rdat = {30'h0, irq_mask};
        `PAG_ADR_REPORT:   next_rdat = report;
        default:           next_rdat = 32'h0;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        `PAG_ADR_CTRL: begin
          cw        = merge({28'h0, ctrl}, wb_dat_i, wb_sel_i);
          next_ctrl = pag_pkg::pag_ctrl_type'(cw[`PAG_CTRL_W-1:0]);
        end
        `PAG_ADR_CMD:      action = wb_sel_i[0] & wb_dat_i[`PAG_CMD_ACTION];
        `PAG_ADR_TARGET:   next_target = merge(target, wb_dat_i, wb_sel_i);
        `PAG_ADR_WINDOW:   next_position_window_cmd = merge(position_window_cmd, wb_dat_i,
                                                            wb_sel_i);
        `PAG_ADR_VELOCITY: next_velocity_setpoint_cmd = merge(velocity_setpoint_cmd, wb_dat_i,
                                                              wb_sel_i);
        `PAG_ADR_ACCEL:    next_accel = merge(accel, wb_dat_i, wb_sel_i);
        `PAG_ADR_GEAR_NUM: next_gear_numerator = merge(gear_numerator, wb_dat_i, wb_sel_i);
        `PAG_ADR_GEAR_DEN: next_gear_denominator = merge(gear_denominator, wb_dat_i, wb_sel_i);
        `PAG_ADR_IRQ_MASK: next_irq_mask = wb_dat_i[`PAG_IRQ_W-1:0];
        default: ;
      endcase
    end

    // ------------------------------------------------------------------------
    // Encoder position, one increment per edge of either channel
    // ------------------------------------------------------------------------
    enc_d = quad_step(filt_prev[1:0], filt[1:0]);
    next_enc_pos = enc_pos + {{30{enc_d[1]}}, enc_d};

    // ------------------------------------------------------------------------
    // Frequency ramp in Hz, stepped by accel every millisecond
    // ------------------------------------------------------------------------
    tick = (tick_cnt == RAMP_TICK_CYCLES - 1);
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
    mag = (want_dir != dir) ? 32'h0 : target_freq;
    if (tick || accel == 32'h0) begin
      if (freq < mag) begin
        next_freq = (accel == 32'h0 || mag - freq < accel) ? mag : freq + accel;
      end else if (freq > mag) begin
        next_freq = (accel == 32'h0 || freq - mag < accel) ? mag : freq - accel;
      end
    end
    if (freq == 32'h0) begin
      next_dir = want_dir;
    end
    psum = {1'b0, phase} + {1'b0, freq};
    if (psum >= {1'b0, `PAG_CLK_HZ}) begin
      mstep      = 1'b1;
      next_phase = 32'(psum - {1'b0, `PAG_CLK_HZ});
    end else begin
      next_phase = psum[31:0];
    end

    // ------------------------------------------------------------------------
    // Gear: numerator added per gear pulse, one step per denominator
    // ------------------------------------------------------------------------
    gear_d = quad_step(filt_prev[3:2], filt[3:2]);
    if (ctrl.mode == pag_pkg::PAG_MODE_GEAR) begin
      if (gear_d == 2'h1) begin
        next_gear_acc = gear_acc + {1'b0, gear_num_act};
      end else if (gear_d == 2'h3) begin
        next_gear_acc = gear_acc - {1'b0, gear_num_act};
      end
      if ($signed(gear_acc) >= $signed({1'b0, gear_den_act}) && gear_den_act != 32'h0) begin
        sp_up         = 1'b1;
        next_gear_acc = next_gear_acc - {1'b0, gear_den_act};
      end else if ($signed(gear_acc) <= -$signed({1'b0, gear_den_act}) &&
                   gear_den_act != 32'h0) begin
        sp_dn         = 1'b1;
        next_gear_acc = next_gear_acc + {1'b0, gear_den_act};
      end
    end else begin
      next_gear_acc = 33'h0;
      sp_up = mstep & dir;
      sp_dn = mstep & ~dir;
    end

    // ------------------------------------------------------------------------
    // Job sequencing and acknowledgement
    // ------------------------------------------------------------------------
    diff = target - setpoint;
    err  = target - enc_pos;
    err  = err[31] ? 32'(-err) : err;
    case (state)
      pag_pkg::PAG_ST_IDLE: begin
      end
      pag_pkg::PAG_ST_RUN: begin
        if (ctrl.mode == pag_pkg::PAG_MODE_PTP) begin
          next_want_dir = ~diff[31];
          if (diff == 32'h0) begin
            sp_up            = 1'b0;
            sp_dn            = 1'b0;
            next_freq        = 32'h0;
            next_target_freq = 32'h0;
            next_state       = pag_pkg::PAG_ST_SETTLE;
          end
        end else if (freq == 32'h0) begin
          done_ev    = 1'b1;
          send_x     = 1'b1;
          next_state = pag_pkg::PAG_ST_IDLE;
        end
      end
      pag_pkg::PAG_ST_SETTLE: begin
        if (err <= position_window_cmd) begin
          done_ev     = 1'b1;
          next_state  = pag_pkg::PAG_ST_IDLE;
          next_report = enc_pos;
          next_ack_tx.valid  = 1'b1;
          next_ack_tx.report = ctrl.report_option;
          next_ack_tx.data   = `PAG_ACK_CHAR;
        end
      end
      default: next_state = pag_pkg::PAG_ST_IDLE;
    endcase
    if (ctrl.mode == pag_pkg::PAG_MODE_PTP && state != pag_pkg::PAG_ST_IDLE &&
        !ctrl.auto_run) begin
      abort_ev         = 1'b1;
      done_ev          = 1'b0;
      next_ack_tx      = '0;
      sp_up            = 1'b0;
      sp_dn            = 1'b0;
      next_freq        = 32'h0;
      next_target_freq = 32'h0;
      next_state       = pag_pkg::PAG_ST_IDLE;
    end

    if (action) begin
      case (ctrl.mode)
        pag_pkg::PAG_MODE_PTP: begin
          if (ctrl.auto_run) begin
            next_in_pos      = 1'b0;
            next_target_freq = velocity_setpoint_cmd[31] ? 32'(-velocity_setpoint_cmd)
                                                         : velocity_setpoint_cmd;
            next_state       = pag_pkg::PAG_ST_RUN;
          end
        end
        pag_pkg::PAG_MODE_FREQ: begin
          mag = velocity_setpoint_cmd[31] ? 32'(-velocity_setpoint_cmd) : velocity_setpoint_cmd;
          next_want_dir = ~velocity_setpoint_cmd[31];
          if (mag < `PAG_VEL_MIN) begin
            next_target_freq = 32'h0;
            next_in_pos      = 1'b0;
            next_state       = pag_pkg::PAG_ST_RUN;
          end else begin
            next_target_freq = mag;
            done_ev          = 1'b1;
            send_x           = 1'b1;
            next_state       = pag_pkg::PAG_ST_IDLE;
          end
        end
        pag_pkg::PAG_MODE_GEAR: begin
          next_gear_num_act = gear_numerator;
          next_gear_den_act = gear_denominator;
          done_ev           = 1'b1;
          send_x            = 1'b1;
        end
        default: ;
      endcase
    end
    if (done_ev) begin
      next_in_pos = 1'b1;
    end
    if (send_x) begin
      next_ack_tx.valid  = 1'b1;
      next_ack_tx.report = 1'b0;
      next_ack_tx.data   = `PAG_ACK_CHAR;
    end

    // ------------------------------------------------------------------------
    // Setpoint, step output, interrupts (set wins over write-one clear)
    // ------------------------------------------------------------------------
    if (sp_up) begin
      next_setpoint = setpoint + 32'h1;
    end else if (sp_dn) begin
      next_setpoint = setpoint - 32'h1;
    end
    next_step = sp_up | sp_dn;
    if (sp_up | sp_dn) begin
      next_dir = sp_up;
    end
    ev[`PAG_IRQ_DONE]  = done_ev;
    ev[`PAG_IRQ_ABORT] = abort_ev;
    next_irq_stat = irq_stat;
    if (wr && wb_adr_i == `PAG_ADR_IRQ_STAT && wb_sel_i[0]) begin
      next_irq_stat = irq_stat & ~wb_dat_i[`PAG_IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | ev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl                  <= pag_pkg::pag_ctrl_type'(`PAG_CTRL_RST);
      state                 <= pag_pkg::PAG_ST_IDLE;
      ack_tx                <= '0;
      target                <= 32'h0;
      position_window_cmd   <= 32'h0;
      velocity_setpoint_cmd <= 32'h0;
      accel                 <= `PAG_ACCEL_RST;
      gear_numerator        <= `PAG_GEAR_RST;
      gear_denominator      <= `PAG_GEAR_RST;
      gear_num_act          <= `PAG_GEAR_RST;
      gear_den_act          <= `PAG_GEAR_RST;
      gear_acc              <= 33'h0;
      enc_pos               <= 32'h0;
      setpoint              <= 32'h0;
      freq                  <= 32'h0;
      target_freq           <= 32'h0;
      want_dir              <= 1'b1;
      phase                 <= 32'h0;
      tick_cnt              <= 32'h0;
      in_pos                <= 1'b1;
      dir                   <= 1'b1;
      step                  <= 1'b0;
      report                <= 32'h0;
      irq_stat              <= '0;
      irq_mask              <= '0;
      ack                   <= 1'b0;
      rdat                  <= 32'h0;
    end else begin
      ctrl                  <= next_ctrl;
      state                 <= next_state;
      ack_tx                <= next_ack_tx;
      target                <= next_target;
      position_window_cmd   <= next_position_window_cmd;
      velocity_setpoint_cmd <= next_velocity_setpoint_cmd;
      accel                 <= next_accel;
      gear_numerator        <= next_gear_numerator;
      gear_denominator      <= next_gear_denominator;
      gear_num_act          <= next_gear_num_act;
      gear_den_act          <= next_gear_den_act;
      gear_acc              <= next_gear_acc;
      enc_pos               <= next_enc_pos;
      setpoint              <= next_setpoint;
      freq                  <= next_freq;
      target_freq           <= next_target_freq;
      want_dir              <= next_want_dir;
      phase                 <= next_phase;
      tick_cnt              <= next_tick_cnt;
      in_pos                <= next_in_pos;
      dir                   <= next_dir;
      step                  <= next_step;
      report                <= next_report;
      irq_stat              <= next_irq_stat;
      irq_mask              <= next_irq_mask;
      ack                   <= next_ack;
      rdat                  <= next_rdat;
    end
  end

  assign wb_ack_o                = ack;
  assign wb_dat_o                = rdat;
  assign motor_step_o            = step;
  assign motor_dir_o             = dir;
  assign in_position_flag_o      = in_pos;
  assign ack_tx_o                = ack_tx;
  assign position_report_value_o = report;
  assign irq_o                   = |(irq_stat & irq_mask);

endmodule

// file: tb/pag_top_props.sv
`timescale 1ns/10ps
module pag_top_props (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic                    wb_ack_o,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    motor_step_o,
  input wire logic                    in_position_flag_o,
  input wire logic                    irq_o,
  input wire pag_pkg::pag_ack_tx_type ack_tx_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_ack_late: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
  chk_rd_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
  chk_tx_pulse: assert property (ack_tx_o.valid |=> !ack_tx_o.valid) else $error("tx too long");
  chk_tx_char: assert property (ack_tx_o.valid && !ack_tx_o.report |->
    ack_tx_o.data == 8'h58) else $error("bad ack char");
  chk_tx_in_position_flag: assert property (ack_tx_o.valid |-> in_position_flag_o)
    else $error("ack without in-position");
  chk_in_position_flag_fall: assert property ($fell(in_position_flag_o) |->
    $past(wb_ack_o) && $past(wb_we_i)) else $error("in-position dropped without command");
  cov_report: cover property (ack_tx_o.valid && ack_tx_o.report);
  cov_step: cover property (motor_step_o);
  cov_irq: cover property ($rose(irq_o));
endmodule
bind pag_top pag_top_props u_props (.*);

// file: tb/pag_motor_model.sv
`timescale 1ns/10ps
module pag_motor_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic step_i,
  input  wire logic dir_i,
  input  wire logic gear_go_i,
  output      logic enc_a_o,
  output      logic enc_b_o,
  output      logic gear_a_o,
  output      logic gear_b_o
);
  logic [1:0] enc_q, gear_q;
  always_ff @(posedge clk_i) begin
    enc_q  <= rst_i ? 2'h0 : enc_q + (step_i ? (dir_i ? 2'h1 : 2'h3) : 2'h0);
    gear_q <= rst_i ? 2'h0 : gear_q + {1'b0, gear_go_i};
  end
  // Gray code, A leads B when counting up
  assign enc_a_o  = enc_q[1] ^ enc_q[0];
  assign enc_b_o  = enc_q[1];
  assign gear_a_o = gear_q[1] ^ gear_q[0];
  assign gear_b_o = gear_q[1];
endmodule

// file: tb/positioning_ack_and_gear_scaling_test.sv
`timescale 1ns/10ps
module positioning_ack_and_gear_scaling_test;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, go = 0, ack, stp, dir, inp, irq, ea, eb, ga, gb;
  logic [7:0]  adr = 8'h0;
  logic [31:0] wd = 32'h0, rd, dat, rep, p;
  pag_pkg::pag_ack_tx_type tx;
  int num_errors = 0, checks_done = 0, cycles = 0, steps = 0;
  always #4 clk_i = ~clk_i;
  pag_top #(.RAMP_TICK_CYCLES(10)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
    .wb_dat_o(dat), .wb_ack_o(ack), .enc_a_i(ea), .enc_b_i(eb), .gear_a_i(ga),
    .gear_b_i(gb), .motor_step_o(stp), .motor_dir_o(dir), .in_position_flag_o(inp),
    .ack_tx_o(tx), .position_report_value_o(rep), .irq_o(irq));
  pag_motor_model u_far (.clk_i(clk_i), .rst_i(rst_i), .step_i(stp), .dir_i(dir),
    .gear_go_i(go), .enc_a_o(ea), .enc_b_o(eb), .gear_a_o(ga), .gear_b_o(gb));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
    cyc <= 1'b1; we <= w; adr <= a; wd <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_tx(input logic r);
    int n = 0;
    while (tx.valid !== 1'b1 && n < 9000) begin @(posedge clk_i); n++; end
    chk(tx.valid, 1'b1);
    chk(tx.report, r);
    if (!r) chk(tx.data, 8'h58);
    @(posedge clk_i);
    chk(inp, 1'b1);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (stp === 1'b1) steps++;
    if (cycles == 30000) begin num_errors++; close_out; end
  end
  task automatic t_reset;
    chk(inp, 1'b1);
    chk(stp, 1'b0);
    chk(dir, 1'b1);
    chk(irq, 1'b0);
    chk(rep, 32'h0);
    chk(tx.valid, 1'b0);
    wb(0, 8'h14); chk(rd, 32'h64);
    wb(0, 8'h3c); chk(rd, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_freq;
    wb(1, 8'h00, 32'h1); wb(1, 8'h14, 32'h0); wb(1, 8'h10, 32'h3e8); wb(1, 8'h04, 32'h1);
    wait_tx(0);
    wb(1, 8'h14, 32'ha); wb(1, 8'h10, 32'h4); wb(1, 8'h04, 32'h1);
    chk(inp, 1'b0);
    wait_tx(0);
    wb(0, 8'h2c); chk(rd, 32'h1);
    wb(1, 8'h30, 32'h1); chk(irq, 1'b1);
    wb(1, 8'h2c, 32'h1); chk(irq, 1'b0);
    $display("frequency test done");
  endtask
  task automatic t_gear;
    int s;
    wb(1, 8'h00, 32'h2); wb(1, 8'h18, 32'h2); wb(1, 8'h04, 32'h1);
    wait_tx(0);
    wb(0, 8'h24); p = rd;
    s = steps;
    // Edge spacing keeps two steps per edge within the motor rate
    repeat (6) begin go <= 1'b1; @(posedge clk_i); go <= 1'b0; repeat (7) @(posedge clk_i); end
    repeat (20) @(posedge clk_i);
    wb(0, 8'h24); chk(rd, p + 32'hc);
    chk(steps - s, 32'hc);
    chk(dir, 1'b1);
    p = rd;
    $display("gear test done");
  endtask
  task automatic t_ptp;
    wb(1, 8'h0c, 32'h0); wb(1, 8'h14, 32'h0); wb(1, 8'h10, 32'hf4240); wb(1, 8'h08, p + 32'h14);
    wb(1, 8'h00, 32'hc); wb(1, 8'h04, 32'h1); chk(inp, 1'b0);
    wait_tx(1);
    wb(0, 8'h34); chk(rd, p + 32'h14); chk(rep, p + 32'h14);
    wb(1, 8'h08, p + 32'h384); wb(1, 8'h04, 32'h1);
    repeat (300) @(posedge clk_i);
    wb(1, 8'h00, 32'h0); wb(0, 8'h2c); chk(rd & 32'h2, 32'h2);
    chk(inp, 1'b0);
    $display("positioning test done");
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset; t_freq; t_gear; t_ptp;
    close_out;
  end
endmodule
